// [hdl/isr_pkg.sv]
// Constants for the instrument status reporting block
package isr_pkg;
   // Summary byte bit positions
   localparam int SUM_SWEEP_IDLE = 0;
   localparam int SUM_MOD_ON = 1;
   localparam int SUM_OPER_SRQ = 2;
   localparam int SUM_SYNTH = 3;
   localparam int SUM_MSG_AVAIL = 4;
   localparam int SUM_EVENT = 5;
   localparam int SUM_RQS = 6;
   localparam int SUM_NO_CMD = 7;
   // Standard event bit positions
   localparam int EVT_QUERY_ERR = 2;
   localparam int EVT_EXEC_ERR = 4;
   localparam int EVT_CMD_ERR = 5;
   localparam int EVT_KEY = 6;
   localparam int EVT_PWR_ON = 7;
   localparam logic [7:0] EVT_USED_MASK = 8'hf4;
   // Synthesizer status bit positions
   localparam int SYN_TRIGGERED = 0;
   localparam int SYN_TRIG_ERR = 1;
   localparam int SYN_EXT_CLK = 2;
   localparam int SYN_CLK_ERR = 3;
   localparam int SYN_WARM = 4;
   localparam int SYN_TEST_ERR = 5;
   localparam int SYN_CAL_ERR = 6;
   localparam int SYN_MEM_ERR = 7;
   // Register select codes on the access port
   localparam logic [2:0] SEL_SUMMARY = 3'h0;
   localparam logic [2:0] SEL_EVENT = 3'h1;
   localparam logic [2:0] SEL_EVENT_MASK = 3'h2;
   localparam logic [2:0] SEL_SYNTH = 3'h3;
   localparam logic [2:0] SEL_SYNTH_MASK = 3'h4;
   localparam logic [2:0] SEL_SUM_MASK = 3'h5;
   localparam logic [2:0] SEL_PWR_CLEAR = 3'h6;
   // Reset values
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic PWR_CLEAR_RESET = 1'b1;
   // Result codes queued after test and calibration
   localparam logic [7:0] RESULT_PASS = 8'h00;
   localparam logic [7:0] RESULT_FAIL = 8'h01;
endpackage

// [hdl/isr_sync.sv]
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module isr_sync #(
   parameter int WIDTH = 8
) (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Shift chain; first stage feeds only the second
   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Level changes only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge mclk_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
               level_out[i] <= 1'b0;
            else if (stage2[i] == stage3[i])
               level_out[i] <= stage3[i];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [hdl/isr_status.sv]
// Status bytes, masks, service request and test/cal sequencing
// Function
// - Summary bit 0 reads one when no sweep runs.
// - Summary bit 1 follows the modulation enable.
// - Summary bit 2 set by operator front-panel service request.
// - Summary bit 3 set when any masked synthesizer status bit is set.
// - Summary bit 4 set while the output queue holds unread items.
// - Summary bit 5 set when any enabled standard event bit is set.
// - Event bit 2 set on output queue overflow.
// - Event bit 4 set on command execution failure.
// - Event bit 5 set on command syntax error.
// - Event bit 6 set on any front-panel key press.
// - Event bit 7 set at power on.
// - Synthesizer bit 0 set on burst or sweep trigger.
// - Synthesizer bit 2 reads one while locked to external clock.
// - Synthesizer bit 3 set on external clock fault.
// - Synthesizer bit 5 set when self-test fails.
// - Synthesizer bit 6 set when autocal fails.
// - Synthesizer bit 7 set on power-up memory error.
// - Calibration query starts cal; result queued only when finished.
// - Self-test query starts test; result queued only when finished.
// - Writable readable masks gate synthesizer and summary contributions.
// - Power-on clear bit decides whether status clears at power-up.
// - Clear command clears all latched status bits at once.
`timescale 1ns/1ns
`default_nettype none
module isr_status (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic sweep_running_in,
   input wire logic mod_enable_in,
   input wire logic operator_service_request_in,
   input wire logic ext_locked_in,
   input wire logic ext_clk_fault_in,
   input wire logic warm_done_in,
   input wire logic key_press_in,
   input wire logic trigger_in,
   input wire logic mem_error_in,
   input wire logic out_queue_nonempty_in,
   input wire logic out_queue_overflow_in,
   input wire logic in_queue_empty_in,
   input wire logic exec_error_in,
   input wire logic syntax_error_in,
   input wire logic power_up_in,
   input wire logic clear_all_in,
   input wire logic self_test_query_in,
   input wire logic cal_query_in,
   input wire logic test_done_in,
   input wire logic cal_done_in,
   input wire logic run_failed_in,
   input wire logic reg_read_in,
   input wire logic reg_write_in,
   input wire logic [2:0] reg_sel_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic service_request_out,
   output logic test_start_out,
   output logic cal_start_out,
   output logic result_valid_out,
   output logic [7:0] result_data_out
);
   typedef enum logic [1:0] {IDLE, TESTING, CALIBRATING} isr_run_type;

   logic [7:0] pins_sync, pins_raw;
   logic sweep_sync, mod_sync, oper_sync, lock_sync;
   logic fault_sync, warm_sync, key_sync, trig_sync;
   logic [3:0] edge_prev;
   logic oper_rise, key_rise, trig_rise, fault_rise;
   logic [7:0] event_flags, synth_flags, event_mask, synth_mask;
   logic [7:0] summary_mask, summary, next_event, next_synth;
   logic pwr_clear, oper_flag, clr_event, clr_synth, do_clear;
   isr_run_type run_state;

   assign pins_raw = {sweep_running_in, mod_enable_in,
      operator_service_request_in, ext_locked_in, ext_clk_fault_in,
      warm_done_in, key_press_in, trigger_in};

   isr_sync #(.WIDTH(8)) u_sync (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .pin_in(pins_raw),
      .level_out(pins_sync)
   );

   assign {sweep_sync, mod_sync, oper_sync, lock_sync, fault_sync,
      warm_sync, key_sync, trig_sync} = pins_sync;

   // Edge detection on synchronised levels; idle low matches reset
   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         edge_prev <= 4'h0;
      else
         edge_prev <= {oper_sync, key_sync, trig_sync, fault_sync};
   end
   assign {oper_rise, key_rise, trig_rise, fault_rise} =
      {oper_sync, key_sync, trig_sync, fault_sync} & ~edge_prev;

   // Power-up clear only when enabled; clear command always
   assign do_clear = clear_all_in | (power_up_in & pwr_clear);
   assign clr_event = do_clear | (reg_read_in && reg_sel_in == isr_pkg::SEL_EVENT);
   assign clr_synth = do_clear | (reg_read_in && reg_sel_in == isr_pkg::SEL_SYNTH);

   // Sticky event byte: set wins over clear
   always_comb
   begin
      next_event = clr_event ? 8'h00 : event_flags;
      if (out_queue_overflow_in)
         next_event[isr_pkg::EVT_QUERY_ERR] = 1'b1;
      if (exec_error_in)
         next_event[isr_pkg::EVT_EXEC_ERR] = 1'b1;
      if (syntax_error_in)
         next_event[isr_pkg::EVT_CMD_ERR] = 1'b1;
      if (key_rise)
         next_event[isr_pkg::EVT_KEY] = 1'b1;
      if (power_up_in)
         next_event[isr_pkg::EVT_PWR_ON] = 1'b1;
      next_event = next_event & isr_pkg::EVT_USED_MASK;
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         event_flags <= 8'h00;
      else
         event_flags <= next_event;
   end

   // Sticky synthesizer byte; lock and warm-up bits are live levels
   always_comb
   begin
      next_synth = clr_synth ? 8'h00 : synth_flags;
      if (trig_rise)
         next_synth[isr_pkg::SYN_TRIGGERED] = 1'b1;
      if (trig_rise && sweep_sync)
         next_synth[isr_pkg::SYN_TRIG_ERR] = 1'b1;
      next_synth[isr_pkg::SYN_EXT_CLK] = lock_sync;
      if (fault_rise)
         next_synth[isr_pkg::SYN_CLK_ERR] = 1'b1;
      next_synth[isr_pkg::SYN_WARM] = warm_sync;
      if (run_state == TESTING && test_done_in && run_failed_in)
         next_synth[isr_pkg::SYN_TEST_ERR] = 1'b1;
      if (run_state == CALIBRATING && cal_done_in && run_failed_in)
         next_synth[isr_pkg::SYN_CAL_ERR] = 1'b1;
      if (mem_error_in)
         next_synth[isr_pkg::SYN_MEM_ERR] = 1'b1;
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         synth_flags <= 8'h00;
      else
         synth_flags <= next_synth;
   end

   // Operator service request latch
   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         oper_flag <= 1'b0;
      else if (oper_rise)
         oper_flag <= 1'b1;
      else if (do_clear)
         oper_flag <= 1'b0;
   end

   // Mask and power-on clear registers
   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         event_mask <= isr_pkg::MASK_RESET;
         synth_mask <= isr_pkg::MASK_RESET;
         summary_mask <= isr_pkg::MASK_RESET;
         pwr_clear <= isr_pkg::PWR_CLEAR_RESET;
      end
      else if (reg_write_in)
      begin
         unique case (reg_sel_in)
            isr_pkg::SEL_EVENT_MASK: event_mask <= reg_wdata_in;
            isr_pkg::SEL_SYNTH_MASK: synth_mask <= reg_wdata_in;
            isr_pkg::SEL_SUM_MASK: summary_mask <= reg_wdata_in;
            isr_pkg::SEL_PWR_CLEAR: pwr_clear <= reg_wdata_in[0];
            default: ;
         endcase
      end
   end

   // Summary byte assembled from live state
   always_comb
   begin
      summary = 8'h00;
      summary[isr_pkg::SUM_SWEEP_IDLE] = ~sweep_sync;
      summary[isr_pkg::SUM_MOD_ON] = mod_sync;
      summary[isr_pkg::SUM_OPER_SRQ] = oper_flag;
      summary[isr_pkg::SUM_SYNTH] = |(synth_flags & synth_mask);
      summary[isr_pkg::SUM_MSG_AVAIL] = out_queue_nonempty_in;
      summary[isr_pkg::SUM_EVENT] = |(event_flags & event_mask);
      summary[isr_pkg::SUM_NO_CMD] = in_queue_empty_in;
      summary[isr_pkg::SUM_RQS] = |(summary & summary_mask & 8'hbf);
   end

   // Service request line registered
   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         service_request_out <= 1'b0;
      else
         service_request_out <= summary[isr_pkg::SUM_RQS];
   end

   // Register read data
   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         reg_rdata_out <= 8'h00;
      else if (reg_read_in)
      begin
         unique case (reg_sel_in)
            isr_pkg::SEL_SUMMARY: reg_rdata_out <= summary;
            isr_pkg::SEL_EVENT: reg_rdata_out <= event_flags;
            isr_pkg::SEL_EVENT_MASK: reg_rdata_out <= event_mask;
            isr_pkg::SEL_SYNTH: reg_rdata_out <= synth_flags;
            isr_pkg::SEL_SYNTH_MASK: reg_rdata_out <= synth_mask;
            isr_pkg::SEL_SUM_MASK: reg_rdata_out <= summary_mask;
            isr_pkg::SEL_PWR_CLEAR: reg_rdata_out <= {7'h00, pwr_clear};
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // Test and calibration sequencer; result queued only at done
   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         run_state <= IDLE;
         test_start_out <= 1'b0;
         cal_start_out <= 1'b0;
         result_valid_out <= 1'b0;
         result_data_out <= 8'h00;
      end
      else
      begin
         test_start_out <= 1'b0;
         cal_start_out <= 1'b0;
         result_valid_out <= 1'b0;
         unique case (run_state)
            IDLE:
            begin
               if (self_test_query_in)
               begin
                  run_state <= TESTING;
                  test_start_out <= 1'b1;
               end
               else if (cal_query_in)
               begin
                  run_state <= CALIBRATING;
                  cal_start_out <= 1'b1;
               end
            end
            TESTING, CALIBRATING:
            begin
               if (run_state == TESTING ? test_done_in : cal_done_in)
               begin
                  run_state <= IDLE;
                  result_valid_out <= 1'b1;
                  result_data_out <= run_failed_in ? isr_pkg::RESULT_FAIL
                     : isr_pkg::RESULT_PASS;
               end
            end
            default: run_state <= IDLE;
         endcase
      end
   end

   // Assertions
   sequence s_test_req;
      run_state == IDLE && self_test_query_in;
   endsequence
   property p_test_start;
      @(posedge mclk_in) disable iff (!rst_b_in)
      s_test_req |=> test_start_out && !result_valid_out;
   endproperty
   a_test_start: assert property (p_test_start) else $error("test not started");
   property p_result_at_done;
      @(posedge mclk_in) disable iff (!rst_b_in)
      result_valid_out |-> $past(run_state) != IDLE;
   endproperty
   a_result_at_done: assert property (p_result_at_done) else $error("early result");
   property p_event_unused;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (event_flags & 8'h0b) == 8'h00;
   endproperty
   a_event_unused: assert property (p_event_unused) else $error("unused bit set");
   property p_overflow;
      @(posedge mclk_in) disable iff (!rst_b_in)
      out_queue_overflow_in |=> event_flags[isr_pkg::EVT_QUERY_ERR];
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow lost");
   property p_power_on;
      @(posedge mclk_in) disable iff (!rst_b_in)
      power_up_in |=> event_flags[isr_pkg::EVT_PWR_ON];
   endproperty
   a_power_on: assert property (p_power_on) else $error("power on lost");
   property p_srq;
      @(posedge mclk_in) disable iff (!rst_b_in)
      ##1 service_request_out == $past(|(summary & summary_mask & 8'hbf));
   endproperty
   a_srq: assert property (p_srq) else $error("service line wrong");
   property p_synth_sum;
      @(posedge mclk_in) disable iff (!rst_b_in)
      reg_read_in && reg_sel_in == isr_pkg::SEL_SUMMARY
         |=> reg_rdata_out[isr_pkg::SUM_SYNTH]
         == $past(|(synth_flags & synth_mask));
   endproperty
   a_synth_sum: assert property (p_synth_sum) else $error("synth summary");
   property p_clear;
      @(posedge mclk_in) disable iff (!rst_b_in)
      clear_all_in && !power_up_in && !key_rise && !exec_error_in
         && !syntax_error_in && !out_queue_overflow_in
         |=> event_flags == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");
endmodule
`default_nettype wire

// [sim/isr_host.sv]
// Bus controller model issuing register accesses and clears
`timescale 1ns/1ns
`default_nettype none
module isr_host (
   input wire logic mclk_in,
   input wire logic [7:0] reg_rdata_in,
   output logic reg_read_out,
   output logic reg_write_out,
   output logic [2:0] reg_sel_out,
   output logic [7:0] reg_wdata_out,
   output logic clear_all_out
);
   // Idle bus from time zero
   initial
   begin
      reg_read_out = 1'b0;
      reg_write_out = 1'b0;
      reg_sel_out = 3'h7;
      reg_wdata_out = 8'h5a;
      clear_all_out = 1'b0;
   end
   // Mask or control write; released lines show inverted values
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      @(negedge mclk_in);
      reg_write_out = 1'b1;
      reg_sel_out = sel;
      reg_wdata_out = d;
      @(negedge mclk_in);
      reg_write_out = 1'b0;
      reg_sel_out = ~sel;
      reg_wdata_out = ~d;
   endtask
   // Register read; data taken once it has settled
   task automatic rd(input logic [2:0] sel, output logic [7:0] d);
      @(negedge mclk_in);
      reg_read_out = 1'b1;
      reg_sel_out = sel;
      @(negedge mclk_in);
      reg_read_out = 1'b0;
      reg_sel_out = ~sel;
      @(negedge mclk_in);
      d = reg_rdata_in;
   endtask
   // Clear-all command, one cycle
   task automatic clr;
      @(negedge mclk_in);
      clear_all_out = 1'b1;
      @(negedge mclk_in);
      clear_all_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// [sim/instrument_status_reporting_bench.sv]
// Self-checking bench for the instrument status reporting block
`timescale 1ns/1ns
`default_nettype none
module instrument_status_reporting_bench;
   logic mclk_in, rst_b_in, oq_ne, iq_empty, run_failed;
   logic [7:0] pin;
   logic [8:0] pul;
   logic reg_read, reg_write, clear_all;
   logic [2:0] reg_sel;
   logic [7:0] reg_wdata, reg_rdata, result_data, v;
   logic service_request, test_start, cal_start, result_valid;
   logic [31:0] seed;
   int error_cnt, compares, cyc;

   // Clock, 100 ns period
   initial
   begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end

   isr_status DUT (
      .mclk_in(mclk_in), .rst_b_in(rst_b_in),
      .sweep_running_in(pin[0]), .mod_enable_in(pin[1]),
      .operator_service_request_in(pin[2]), .ext_locked_in(pin[3]),
      .ext_clk_fault_in(pin[4]), .warm_done_in(pin[5]),
      .key_press_in(pin[6]), .trigger_in(pin[7]),
      .mem_error_in(pul[0]), .out_queue_nonempty_in(oq_ne),
      .out_queue_overflow_in(pul[1]), .in_queue_empty_in(iq_empty),
      .exec_error_in(pul[2]), .syntax_error_in(pul[3]),
      .power_up_in(pul[4]), .clear_all_in(clear_all),
      .self_test_query_in(pul[5]), .cal_query_in(pul[6]),
      .test_done_in(pul[7]), .cal_done_in(pul[8]),
      .run_failed_in(run_failed), .reg_read_in(reg_read),
      .reg_write_in(reg_write), .reg_sel_in(reg_sel),
      .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
      .service_request_out(service_request),
      .test_start_out(test_start), .cal_start_out(cal_start),
      .result_valid_out(result_valid), .result_data_out(result_data)
   );

   isr_host host (
      .mclk_in(mclk_in), .reg_rdata_in(reg_rdata),
      .reg_read_out(reg_read), .reg_write_out(reg_write),
      .reg_sel_out(reg_sel), .reg_wdata_out(reg_wdata),
      .clear_all_out(clear_all)
   );

   // Xorshift step for repeatable stimulus
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   // Summary byte from sweep, mod, queue levels, nothing latched
   function automatic logic [7:0] lvl_exp(input logic [3:0] s);
      return {s[3], 1'b0, 1'b0, s[2], 1'b0, 1'b0, s[1], ~s[0]};
   endfunction
   // Event byte after one pulse on a given event input
   function automatic logic [7:0] evt_exp(input int i);
      case (i)
         1: return 8'h04;
         2: return 8'h10;
         3: return 8'h20;
         default: return 8'h80;
      endcase
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   task automatic pulse(input int b);
      pul[b] = 1'b1;
      @(negedge mclk_in);
      pul[b] = 1'b0;
      wait_n(2);
   endtask
   // Pin edge held long enough to pass the synchroniser
   task automatic pin_edge(input int b);
      pin[b] = 1'b1;
      wait_n(6);
      pin[b] = 1'b0;
      wait_n(6);
   endtask
   task automatic rd(input logic [2:0] sel);
      host.rd(sel, v);
   endtask
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   // Query, repeated query while busy, then done with given outcome
   task automatic run(input int q, input logic fail, input logic [7:0] es);
      logic [3:0] st, cs, rv;
      st = 4'h0;
      cs = 4'h0;
      rv = 4'h0;
      pul[q] = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         @(negedge mclk_in);
         pul[q] = (i == 3);
         st = st + test_start;
         cs = cs + cal_start;
         rv = rv + result_valid;
      end
      chk({st, cs}, (q == 5) ? 8'h10 : 8'h01);
      chk({4'h0, rv}, 8'h00);
      pul[q + 2] = 1'b1;
      run_failed = fail;
      for (int i = 0; i < 4; i++)
      begin
         @(negedge mclk_in);
         pul[q + 2] = 1'b0;
         rv = rv + result_valid;
      end
      chk({4'h0, rv}, 8'h01);
      chk(result_data, {7'h00, fail});
      rd(isr_pkg::SEL_SYNTH);
      chk(v & 8'h60, es);
      note("test and cal run");
   endtask
   task automatic conclude;
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Hang guard
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         conclude();
      end
   end

   // Main sequence
   initial
   begin
      {rst_b_in, oq_ne, iq_empty, run_failed} = 4'h0;
      pin = 8'h00;
      pul = 9'h000;
      seed = 32'hccda;
      repeat (5) @(negedge mclk_in);
      rst_b_in = 1'b1;
      rd(isr_pkg::SEL_SYNTH_MASK);
      chk(v, isr_pkg::MASK_RESET);
      rd(isr_pkg::SEL_SUM_MASK);
      chk(v, isr_pkg::MASK_RESET);
      rd(isr_pkg::SEL_PWR_CLEAR);
      chk(v, {7'h00, isr_pkg::PWR_CLEAR_RESET});
      note("reset values");
      repeat (16)
      begin
         seed = xs(seed);
         pin[1:0] = seed[1:0];
         oq_ne = seed[2];
         iq_empty = seed[3];
         host.wr(isr_pkg::SEL_EVENT_MASK, seed[15:8]);
         rd(isr_pkg::SEL_EVENT_MASK);
         chk(v, seed[15:8]);
         wait_n(6);
         rd(isr_pkg::SEL_SUMMARY);
         chk(v, lvl_exp(seed[3:0]));
      end
      {oq_ne, iq_empty} = 2'b00;
      pin = 8'h00;
      host.wr(isr_pkg::SEL_EVENT_MASK, 8'h00);
      wait_n(6);
      note("summary levels");
      for (int i = 1; i < 5; i++)
      begin
         pulse(i);
         rd(isr_pkg::SEL_EVENT);
         chk(v, evt_exp(i));
         rd(isr_pkg::SEL_EVENT);
         chk(v, 8'h00);
      end
      pin_edge(6);
      rd(isr_pkg::SEL_EVENT);
      chk(v, 8'h40);
      note("event bits");
      pin_edge(7);
      rd(isr_pkg::SEL_SYNTH);
      chk(v, 8'h01);
      pin_edge(4);
      rd(isr_pkg::SEL_SYNTH);
      chk(v, 8'h08);
      pulse(0);
      rd(isr_pkg::SEL_SYNTH);
      chk(v, 8'h80);
      for (int b = 3; b < 6; b += 2)
      begin
         pin[b] = 1'b1;
         wait_n(6);
         repeat (2)
         begin
            rd(isr_pkg::SEL_SYNTH);
            chk(v, 8'h01 << (b - 1));
         end
         pin[b] = 1'b0;
         wait_n(6);
      end
      pin[0] = 1'b1;
      wait_n(6);
      pin_edge(7);
      rd(isr_pkg::SEL_SYNTH);
      chk(v & 8'h02, 8'h02);
      pin[0] = 1'b0;
      wait_n(6);
      note("synth bits");
      host.wr(isr_pkg::SEL_SYNTH_MASK, 8'h01);
      host.wr(isr_pkg::SEL_SUM_MASK, 8'h08);
      rd(isr_pkg::SEL_SYNTH_MASK);
      chk(v, 8'h01);
      pin_edge(7);
      rd(isr_pkg::SEL_SUMMARY);
      chk(v, 8'h49);
      chk({7'h00, service_request}, 8'h01);
      host.clr();
      rd(isr_pkg::SEL_SUMMARY);
      chk(v, 8'h01);
      chk({7'h00, service_request}, 8'h00);
      host.wr(isr_pkg::SEL_EVENT_MASK, 8'h20);
      host.wr(isr_pkg::SEL_SUM_MASK, 8'h20);
      pulse(3);
      rd(isr_pkg::SEL_SUMMARY);
      chk(v, 8'h61);
      rd(isr_pkg::SEL_EVENT);
      chk(v, 8'h20);
      rd(isr_pkg::SEL_SUMMARY);
      chk(v, 8'h01);
      pin_edge(2);
      rd(isr_pkg::SEL_SUMMARY);
      chk(v & 8'h04, 8'h04);
      host.clr();
      note("masks and service request");
      host.wr(isr_pkg::SEL_PWR_CLEAR, 8'h00);
      rd(isr_pkg::SEL_PWR_CLEAR);
      chk(v, 8'h00);
      pulse(3);
      pulse(4);
      rd(isr_pkg::SEL_EVENT);
      chk(v, 8'ha0);
      host.wr(isr_pkg::SEL_PWR_CLEAR, 8'h01);
      pulse(3);
      pulse(4);
      rd(isr_pkg::SEL_EVENT);
      chk(v, 8'h80);
      note("power-on clear");
      host.wr(isr_pkg::SEL_SUM_MASK, 8'h01);
      wait_n(2);
      chk({7'h00, service_request}, 8'h01);
      rst_b_in = 1'b0;
      wait_n(5);
      rst_b_in = 1'b1;
      chk({7'h00, service_request}, 8'h00);
      rd(isr_pkg::SEL_SUM_MASK);
      chk(v, isr_pkg::MASK_RESET);
      host.wr(3'h7, 8'hff);
      rd(isr_pkg::SEL_PWR_CLEAR);
      chk(v, {7'h00, isr_pkg::PWR_CLEAR_RESET});
      rd(3'h7);
      chk(v, 8'h00);
      note("mid-run reset");
      run(5, 1'b1, 8'h20);
      run(6, 1'b1, 8'h40);
      run(6, 1'b0, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
